// ==== tpc_top.sv ====
// Shared and second-timer prescalers, first 8-bit timer, AXI4-Lite registers
//
// Behaviour
// R01: Writing one to the shared prescaler reset bit clears the shared 10-bit prescaler.
// R02: That reset bit clears itself, ignores a written zero and always reads zero.
// R03: The async prescaler reset bit clears the second prescaler and reads one until done only in async mode.
// R04: One shared prescaler reset restarts the tap phases of both the first and the 16-bit timer; only the first timer is built here.
// R05: The shared prescaler divides the main clock by 10 bits with taps at 8, 64, 256 and 1024.
// R06: Clock select 0..7 means stop, clock, div8, div64, div256, div1024, pin fall, pin rise.
// R07: In pin modes the count input pin clocks the timer regardless of the pin's direction.
// R08: The count input pin is sampled on each rising main clock edge before edge detection.
// R09: The external source keeps at least one clock period between count pin transitions.
// R10: The first timer count is an 8-bit up-counter readable and writable by software.
// R11: After a count write with a source selected, counting resumes in the very next cycle.
// R12: An overflow flag in the timer flag register is gated by the mask register onto an interrupt.
// R13: Reserved bits 7..3 of clock select and 7..4 of prescaler control read as zero.
// R14: The second timer runs from the main clock unless async select picks the crystal input.
// R15: While async select is set both crystal pins are released from their port functions.
// R16: The board attaches a crystal across the oscillator pins rather than a driven clock.
// R17: A counting event that wraps the count from ff to 00 sets the overflow flag.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tpc_top
	import tpc_pkg::*;
#(
	parameter int PRESC_W = 10
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	// AXI4-Lite slave
	input  wire logic [TPC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [TPC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Pins and timer outputs
	input  wire logic                  count_input_pin,
	input  wire logic                  crystal_pin_in,
	output logic                       crystal_pins_released,
	output logic                       second_timer_source_clock_sel,
	output logic [PRESC_W-1:0]         shared_prescale,
	output logic [PRESC_W-1:0]         second_prescale,
	output logic                       first_timer_tick,
	output logic                       first_timer_ovf_irq
);
	import tpc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Tap decode for one clock select code
	function automatic logic csel_tick(input logic [2:0] cs,
		input logic [PRESC_W-1:0] pc, input logic pin_rise,
		input logic pin_fall);
		logic t;
		t = 1'b0;
		case (cs)
			TPC_CS_STOP:  t = 1'b0;
			TPC_CS_CLK:   t = 1'b1;
			TPC_CS_DIV8:  t = &pc[TPC_TAP8_W-1:0];
			TPC_CS_DIV64: t = &pc[TPC_TAP64_W-1:0];
			TPC_CS_D256:  t = &pc[TPC_TAP256_W-1:0];
			TPC_CS_D1024: t = &pc;
			TPC_CS_EXTF:  t = pin_fall;
			TPC_CS_EXTR:  t = pin_rise;
			default:      t = 1'b0;
		endcase
		return t;
	endfunction : csel_tick

	////////////////////////////////////////////////////////////////////////
	// Bus state
	logic                  aw_full_r, aw_full_nxt;
	logic [TPC_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
	logic                  w_full_r, w_full_nxt;
	logic [7:0]            w_data_r, w_data_nxt;
	logic                  w_lane0_r, w_lane0_nxt;
	logic                  bvalid_r, bvalid_nxt;
	logic [1:0]            bresp_r, bresp_nxt;
	logic                  rvalid_r, rvalid_nxt;
	logic [31:0]           rdata_r, rdata_nxt;
	logic [1:0]            rresp_r, rresp_nxt;
	logic                  wr_go;
	logic                  wr_hit;
	logic                  awready_r, wready_r, arready_r;

	// Timer state
	logic [2:0]            csel_r, csel_nxt;
	logic [7:0]            cnt_r, cnt_nxt;
	logic                  ovf_flag_r, ovf_flag_nxt;
	logic                  ovf_mask_r, ovf_mask_nxt;
	logic                  async_sel_r, async_sel_nxt;
	logic                  async_rst_pend_r, async_rst_pend_nxt;
	logic                  shared_clr_r, shared_clr_nxt;
	logic                  tick_r, tick_nxt;
	logic                  irq_r, irq_nxt;
	logic                  second_clr;
	logic                  second_adv;
	logic [PRESC_W-1:0]    shared_pc;
	logic [PRESC_W-1:0]    second_pc;
	logic                  t_rise, t_fall, x_rise;
	logic                  tick;

	////////////////////////////////////////////////////////////////////////
	// Sub-blocks
	tpc_pin_edge u_count_pin (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin     (count_input_pin), // R07
		.rise    (t_rise),
		.fall    (t_fall)
	);

	tpc_pin_edge u_xtal_pin (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin     (crystal_pin_in),
		.rise    (x_rise),
		.fall    ()
	);

	// Shared prescaler: its clear serves the first timer only; the second timer has its own
	tpc_prescaler #(.WIDTH(PRESC_W)) u_shared (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (shared_clr_r), // R01 R04
		.advance (1'b1), // R05
		.count   (shared_pc)
	);

	tpc_prescaler #(.WIDTH(PRESC_W)) u_second (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (second_clr), // R03
		.advance (second_adv),
		.count   (second_pc)
	);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	assign wr_go  = aw_full_r & w_full_r & ~bvalid_r;
	assign wr_hit = wr_go & w_lane0_r;

	always_comb begin
		aw_full_nxt = aw_full_r;
		aw_addr_nxt = aw_addr_r;
		w_full_nxt  = w_full_r;
		w_data_nxt  = w_data_r;
		w_lane0_nxt = w_lane0_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		if (s_axi_awvalid && !aw_full_r) begin
			aw_full_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_full_r) begin
			w_full_nxt  = 1'b1;
			w_data_nxt  = s_axi_wdata[7:0];
			w_lane0_nxt = s_axi_wstrb[0];
		end
		if (wr_go) begin
			aw_full_nxt = 1'b0;
			w_full_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			case (aw_addr_r)
				TPC_PMC_ADDR, TPC_CSEL_ADDR, TPC_CNT_ADDR,
				TPC_FLAG_ADDR, TPC_MASK_ADDR, TPC_ASR_ADDR:
					bresp_nxt = TPC_RESP_OKAY;
				default: bresp_nxt = TPC_RESP_SLVERR;
			endcase
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = TPC_RESP_OKAY;
			rdata_nxt  = 32'h0000_0000;
			case (s_axi_araddr)
				TPC_PMC_ADDR: // R02 R13
					rdata_nxt[TPC_PMC_ASYNC_RST] = async_rst_pend_r; // R03
				TPC_CSEL_ADDR: rdata_nxt[2:0] = csel_r; // R13
				TPC_CNT_ADDR:  rdata_nxt[7:0] = cnt_r; // R10
				TPC_FLAG_ADDR: rdata_nxt[TPC_FLAG_OVF] = ovf_flag_r;
				TPC_MASK_ADDR: rdata_nxt[TPC_MASK_OVF] = ovf_mask_r;
				TPC_ASR_ADDR:  rdata_nxt[TPC_ASR_ASYNC_SEL] = async_sel_r;
				default:       rresp_nxt = TPC_RESP_SLVERR;
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= '0;
			w_full_r  <= 1'b0;
			w_data_r  <= 8'h00;
			w_lane0_r <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= TPC_RESP_OKAY;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= TPC_RESP_OKAY;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			arready_r <= 1'b1;
		end else begin
			aw_full_r <= aw_full_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_full_r  <= w_full_nxt;
			w_data_r  <= w_data_nxt;
			w_lane0_r <= w_lane0_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
			awready_r <= ~aw_full_nxt;
			wready_r  <= ~w_full_nxt;
			arready_r <= ~rvalid_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	////////////////////////////////////////////////////////////////////////
	// Timer and prescaler control
	assign tick = csel_tick(csel_r, shared_pc, t_rise, t_fall); // R06

	// Second prescaler steps on rising crystal edges in async mode, else every clock
	assign second_adv = async_sel_r ? x_rise : 1'b1; // R14
	assign second_clr = async_sel_r ? (async_rst_pend_r & x_rise)
		: (wr_hit && aw_addr_r == TPC_PMC_ADDR
		&& w_data_r[TPC_PMC_ASYNC_RST]); // R03

	always_comb begin
		csel_nxt           = csel_r;
		cnt_nxt            = cnt_r;
		ovf_flag_nxt       = ovf_flag_r;
		ovf_mask_nxt       = ovf_mask_r;
		async_sel_nxt      = async_sel_r;
		async_rst_pend_nxt = async_rst_pend_r;
		shared_clr_nxt     = 1'b0; // R02
		// Pending async reset ends on the crystal edge that applies it
		if (!async_sel_r || x_rise)
			async_rst_pend_nxt = 1'b0; // R03
		// A written count wins this cycle; counting resumes on the next
		if (wr_hit && aw_addr_r == TPC_CNT_ADDR)
			cnt_nxt = w_data_r; // R10 R11
		else if (tick)
			cnt_nxt = cnt_r + 8'h01; // R10
		if (wr_hit) begin
			case (aw_addr_r)
				TPC_PMC_ADDR: begin
					shared_clr_nxt = w_data_r[TPC_PMC_SHARED_RST]; // R01
					if (async_sel_r && w_data_r[TPC_PMC_ASYNC_RST])
						async_rst_pend_nxt = 1'b1; // R03
				end
				TPC_CSEL_ADDR: csel_nxt = w_data_r[TPC_CSEL_W-1:0];
				TPC_FLAG_ADDR:
					if (w_data_r[TPC_FLAG_OVF])
						ovf_flag_nxt = 1'b0;
				TPC_MASK_ADDR: ovf_mask_nxt = w_data_r[TPC_MASK_OVF];
				TPC_ASR_ADDR:
					async_sel_nxt = w_data_r[TPC_ASR_ASYNC_SEL]; // R14
				default: ;
			endcase
		end
		// Overflow set wins over a clear in the same cycle
		if (tick && cnt_r == 8'hff && !(wr_hit && aw_addr_r == TPC_CNT_ADDR))
			ovf_flag_nxt = 1'b1; // R17 R12
		tick_nxt = tick;
		irq_nxt  = ovf_flag_nxt & ovf_mask_nxt; // R12
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			csel_r           <= TPC_CSEL_RST;
			cnt_r            <= TPC_CNT_RST;
			ovf_flag_r       <= 1'b0;
			ovf_mask_r       <= 1'b0;
			async_sel_r      <= 1'b0;
			async_rst_pend_r <= 1'b0;
			shared_clr_r     <= 1'b0;
			tick_r           <= 1'b0;
			irq_r            <= 1'b0;
		end else begin
			csel_r           <= csel_nxt;
			cnt_r            <= cnt_nxt;
			ovf_flag_r       <= ovf_flag_nxt;
			ovf_mask_r       <= ovf_mask_nxt;
			async_sel_r      <= async_sel_nxt;
			async_rst_pend_r <= async_rst_pend_nxt;
			shared_clr_r     <= shared_clr_nxt;
			tick_r           <= tick_nxt;
			irq_r            <= irq_nxt;
		end
	end

	assign crystal_pins_released         = async_sel_r; // R15
	assign second_timer_source_clock_sel = async_sel_r; // R14
	assign shared_prescale               = shared_pc;
	assign second_prescale               = second_pc;
	assign first_timer_tick              = tick_r;
	assign first_timer_ovf_irq           = irq_r;
endmodule : tpc_top
`default_nettype wire

// ==== tpc_pkg.sv ====
// Shared constants for the timer prescalers and first timer block
`default_nettype none
package tpc_pkg;
	// Register byte addresses on the AXI4-Lite bus
	localparam logic [7:0] TPC_PMC_ADDR  = 8'h00;
	localparam logic [7:0] TPC_CSEL_ADDR = 8'h04;
	localparam logic [7:0] TPC_CNT_ADDR  = 8'h08;
	localparam logic [7:0] TPC_FLAG_ADDR = 8'h0c;
	localparam logic [7:0] TPC_MASK_ADDR = 8'h10;
	localparam logic [7:0] TPC_ASR_ADDR  = 8'h14;
	localparam int         TPC_ADDR_W    = 8;

	// Field positions
	localparam int TPC_PMC_SHARED_RST = 0;
	localparam int TPC_PMC_ASYNC_RST  = 1;
	localparam int TPC_FLAG_OVF       = 0;
	localparam int TPC_MASK_OVF       = 0;
	localparam int TPC_ASR_ASYNC_SEL  = 3;
	localparam int TPC_CSEL_W         = 3;

	// Reset values
	localparam logic [2:0] TPC_CSEL_RST = 3'h0;
	localparam logic [7:0] TPC_CNT_RST  = 8'h00;

	// Prescaler geometry and tap widths (divide by 2**n)
	localparam int TPC_PRESC_W  = 10;
	localparam int TPC_TAP8_W   = 3;
	localparam int TPC_TAP64_W  = 6;
	localparam int TPC_TAP256_W = 8;

	// Clock select codes
	typedef enum logic [2:0] {
		TPC_CS_STOP  = 3'h0,
		TPC_CS_CLK   = 3'h1,
		TPC_CS_DIV8  = 3'h2,
		TPC_CS_DIV64 = 3'h3,
		TPC_CS_D256  = 3'h4,
		TPC_CS_D1024 = 3'h5,
		TPC_CS_EXTF  = 3'h6,
		TPC_CS_EXTR  = 3'h7
	} tpc_csel_t;

	// AXI responses
	localparam logic [1:0] TPC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] TPC_RESP_SLVERR = 2'h2;

	// Nominal watch crystal frequency for the second timer, in Hz
	localparam int TPC_XTAL_HZ = 32768;
endpackage : tpc_pkg
`default_nettype wire

// ==== tpc_prescaler.sv ====
// Free-running prescaler counter with synchronous clear and advance
`timescale 1ns/1ps
`default_nettype none
module tpc_prescaler #(
	parameter int WIDTH = 10
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             advance,
	output logic      [WIDTH-1:0] count
);
	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;

	always_comb begin
		count_nxt = count_r;
		if (clear)
			count_nxt = '0;
		else if (advance)
			count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			count_r <= '0;
		else
			count_r <= count_nxt;
	end

	assign count = count_r;
endmodule : tpc_prescaler
`default_nettype wire

// ==== tpc_pin_edge.sv ====
// Two-stage synchroniser with rise and fall detection on the synced level
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_edge (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	logic meta_r;
	logic sync_r;
	logic last_r;
	logic [2:0] stage_nxt;

	// Pin sampled on each rising clock edge before edge detection
	always_comb begin
		stage_nxt = {pin, meta_r, sync_r}; // R08
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= stage_nxt[2];
			sync_r <= stage_nxt[1];
			last_r <= stage_nxt[0];
		end
	end

	assign rise = sync_r & ~last_r;
	assign fall = ~sync_r & last_r;
endmodule : tpc_pin_edge
`default_nettype wire

// ==== tpc_top_monitor.sv ====
// Checker for the prescalers and first timer
`timescale 1ns/1ps
`default_nettype none
module tpc_top_monitor #(
	parameter int PRESC_W = 10
) (
	input wire logic                           ref_clk,
	input wire logic                           rst_n,
	input wire logic [tpc_pkg::TPC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic                           s_axi_awvalid,
	input wire logic                           s_axi_awready,
	input wire logic [31:0]                    s_axi_wdata,
	input wire logic                           s_axi_wvalid,
	input wire logic                           s_axi_wready,
	input wire logic                           s_axi_bvalid,
	input wire logic [tpc_pkg::TPC_ADDR_W-1:0] s_axi_araddr,
	input wire logic                           s_axi_arvalid,
	input wire logic                           s_axi_arready,
	input wire logic [31:0]                    s_axi_rdata,
	input wire logic                           s_axi_rvalid,
	input wire logic [PRESC_W-1:0]             shared_prescale,
	input wire logic                           first_timer_tick,
	input wire logic                           crystal_pins_released,
	input wire logic                           second_timer_source_clock_sel
);
	import tpc_pkg::*;
	logic [7:0] ar_r, ar_nxt, aw_r, aw_nxt, wd_r, wd_nxt;
	logic [2:0] cs_r, cs_nxt;
	logic       bv_r, bv_nxt;

	////////////////////////////////////////////////////////////////////////
	// Track last addresses and the clock select as software wrote it
	always_comb begin
		ar_nxt = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_r;
		aw_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_r;
		wd_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : wd_r;
		bv_nxt = s_axi_bvalid;
		cs_nxt = (s_axi_bvalid && !bv_r && aw_r == TPC_CSEL_ADDR)
			? wd_r[2:0] : cs_r;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ar_r <= 8'h00;
			aw_r <= 8'h00;
			wd_r <= 8'h00;
			bv_r <= 1'b0;
			cs_r <= 3'h0;
		end else begin
			ar_r <= ar_nxt;
			aw_r <= aw_nxt;
			wd_r <= wd_nxt;
			bv_r <= bv_nxt;
			cs_r <= cs_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Mode held for three samples, so the check lags any mode change
	sequence s_held(m);
		cs_r == m && $past(cs_r) == m && $past(cs_r, 2) == m;
	endsequence

	a_pmc_read: assert property (
		s_axi_rvalid && ar_r == TPC_PMC_ADDR
		|-> s_axi_rdata[31:4] == 28'h0 && !s_axi_rdata[0])
		else $error("control read shows stored bits");
	a_async_read: assert property (
		s_axi_rvalid && ar_r == TPC_PMC_ADDR
		&& !second_timer_source_clock_sel |-> !s_axi_rdata[1])
		else $error("async reset bit set in sync mode");
	a_csel_read: assert property (
		s_axi_rvalid && ar_r == TPC_CSEL_ADDR |-> s_axi_rdata[31:3] == 29'h0)
		else $error("clock select reserved bits set");
	a_pins_free: assert property (
		crystal_pins_released == second_timer_source_clock_sel)
		else $error("crystal pins not tied to async select");
	a_async_write: assert property (
		$rose(s_axi_bvalid) && aw_r == TPC_ASR_ADDR
		|-> second_timer_source_clock_sel == wd_r[TPC_ASR_ASYNC_SEL])
		else $error("async select does not follow write");
	a_shared_clr: assert property (
		$rose(s_axi_bvalid) && aw_r == TPC_PMC_ADDR && wd_r[0] |-> ##[1:3] shared_prescale == '0)
		else $error("shared prescaler not cleared");
	a_presc_step: assert property (
		shared_prescale != '0 |-> shared_prescale == $past(shared_prescale) + 1'b1)
		else $error("shared prescaler skipped");
	a_div8_tap: assert property (
		s_held(TPC_CS_DIV8) ##0 first_timer_tick
		|-> $past(shared_prescale[2:0]) == 3'h7 || $past(shared_prescale[2:0], 2) == 3'h7)
		else $error("div8 tick off tap");
	a_stop_still: assert property (
		s_held(TPC_CS_STOP) |-> !first_timer_tick)
		else $error("tick while stopped");
	a_clk_every: assert property (
		s_held(TPC_CS_CLK) |-> first_timer_tick)
		else $error("no tick in main clock mode");

	c_div8: cover property (s_held(TPC_CS_DIV8) ##0 first_timer_tick);
	c_pend: cover property (s_axi_rvalid && ar_r == TPC_PMC_ADDR && s_axi_rdata[1]);
	c_async: cover property ($rose(crystal_pins_released));
endmodule : tpc_top_monitor

bind tpc_top tpc_top_monitor #(.PRESC_W(PRESC_W)) u_tpc_top_monitor (
	.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .shared_prescale(shared_prescale),
	.first_timer_tick(first_timer_tick),
	.crystal_pins_released(crystal_pins_released),
	.second_timer_source_clock_sel(second_timer_source_clock_sel));
`default_nettype wire

// ==== tpc_pulse_src.sv ====
// Count pulse source and watch crystal model
`timescale 1ns/1ps
`default_nettype none
module tpc_pulse_src (
	input wire logic       ref_clk,
	input wire logic       go,
	input wire logic [3:0] num,
	input wire logic       xtal_en,
	output logic           busy,
	output var logic       pin,
	output var logic       xtal
);
	logic [4:0] left;
	logic [1:0] ph;
	initial begin
		left = 5'h00;
		ph = 2'h0;
		pin = 1'b0;
		xtal = 1'b0;
	end
	assign busy = left != 5'h00;
	// Two clocks between pin transitions; crystal swings on its own
	always @(posedge ref_clk) begin
		ph <= ph + 2'h1;
		if (go)
			left <= {num, 1'b0};
		else if (busy && ph[0]) begin
			pin <= ~pin;
			left <= left - 5'h01;
		end
		if (xtal_en && ph == 2'h3)
			xtal <= ~xtal;
	end
endmodule : tpc_pulse_src
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the prescalers and first timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tpc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        go = 1'b0;
	logic [3:0]  num = 4'h0;
	logic        xtal_en = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, first_timer_tick, first_timer_ovf_irq, busy;
	logic        count_input_pin, crystal_pin_in, crystal_pins_released;
	logic        second_timer_source_clock_sel;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [9:0]  shared_prescale, second_prescale;
	logic [33:0] exp_q[$];
	logic [31:0] rnd = 32'h0000004c;
	logic [7:0]  v;
	logic [3:0]  n;
	logic [8:0]  s;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	tpc_top u_tpc_top (.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .count_input_pin(count_input_pin),
		.crystal_pin_in(crystal_pin_in),
		.crystal_pins_released(crystal_pins_released),
		.second_timer_source_clock_sel(second_timer_source_clock_sel),
		.shared_prescale(shared_prescale), .second_prescale(second_prescale),
		.first_timer_tick(first_timer_tick),
		.first_timer_ovf_irq(first_timer_ovf_irq));
	tpc_pulse_src u_tpc_pulse_src (.ref_clk(ref_clk), .go(go), .num(num),
		.xtal_en(xtal_en), .busy(busy), .pin(count_input_pin),
		.xtal(crystal_pin_in));

	always #20 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	function automatic logic [33:0] ok(input logic [7:0] d);
		return {TPC_RESP_OKAY, 24'h0, d};
	endfunction : ok

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		exp_q.push_back(e);
		do begin
			@(posedge ref_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic pulses(input logic [3:0] k);
		@(posedge ref_clk);
		go <= 1'b1;
		num <= k;
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
		while (busy)
			@(posedge ref_clk);
		repeat (6) @(posedge ref_clk);
	endtask : pulses

	task automatic settle();
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle

	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk)
		if (s_axi_rvalid && s_axi_rready)
			check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(8'(4 * i), ok(8'h00));
		rd(8'h18, {TPC_RESP_SLVERR, 32'h0});
		wr(8'h18, 8'h55);
		check({32'h0, s_axi_bresp}, {32'h0, TPC_RESP_SLVERR});
		$display("test reset values done");
		wr(TPC_CSEL_ADDR, 8'hff);
		check({32'h0, s_axi_bresp}, {32'h0, TPC_RESP_OKAY});
		rd(TPC_CSEL_ADDR, ok(8'h07));
		wr(TPC_PMC_ADDR, 8'hff);
		@(negedge ref_clk);
		check({24'h0, shared_prescale}, 34'h0);
		check({24'h0, second_prescale}, 34'h1);
		rd(TPC_PMC_ADDR, ok(8'h00));
		$display("test reserved bits done");
		for (int m = 1; m < 6; m++) begin
			wr(TPC_CSEL_ADDR, 8'(m));
			wr(TPC_PMC_ADDR, 8'h01);
			repeat (1100) @(posedge ref_clk);
		end
		wr(TPC_CSEL_ADDR, 8'h01);
		wr(TPC_CNT_ADDR, 8'h40);
		rd(TPC_CNT_ADDR, ok(8'h42));
		wr(TPC_CSEL_ADDR, 8'h00);
		repeat (20) @(posedge ref_clk);
		$display("test prescaler modes done");
		wr(TPC_FLAG_ADDR, 8'h01);
		rd(TPC_FLAG_ADDR, ok(8'h00));
		wr(TPC_MASK_ADDR, 8'h01);
		wr(TPC_CSEL_ADDR, 8'h07);
		wr(TPC_CNT_ADDR, 8'hfe);
		pulses(4'h3);
		rd(TPC_CNT_ADDR, ok(8'h01));
		rd(TPC_FLAG_ADDR, ok(8'h01));
		settle();
		check({33'h0, first_timer_ovf_irq}, 34'h1);
		wr(TPC_MASK_ADDR, 8'h00);
		settle();
		check({33'h0, first_timer_ovf_irq}, 34'h0);
		wr(TPC_FLAG_ADDR, 8'h01);
		for (int k = 0; k < 6; k++) begin
			rnd = xs(rnd);
			v = rnd[7:0];
			n = {1'b0, rnd[10:8]} + 4'h1;
			s = {1'b0, v} + {5'h0, n};
			wr(TPC_CSEL_ADDR, 8'(6 + k % 2));
			wr(TPC_CNT_ADDR, v);
			pulses(n);
			rd(TPC_CNT_ADDR, ok(s[7:0]));
			rd(TPC_FLAG_ADDR, ok({7'h0, s[8]}));
			wr(TPC_FLAG_ADDR, 8'h01);
		end
		$display("test external counting done");
		wr(TPC_ASR_ADDR, 8'h08);
		settle();
		check({33'h0, second_timer_source_clock_sel}, 34'h1);
		check({33'h0, crystal_pins_released}, 34'h1);
		wr(TPC_PMC_ADDR, 8'h02);
		rd(TPC_PMC_ADDR, ok(8'h02));
		@(posedge ref_clk);
		xtal_en <= 1'b1;
		repeat (40) @(posedge ref_clk);
		rd(TPC_PMC_ADDR, ok(8'h00));
		rd(TPC_ASR_ADDR, ok(8'h08));
		wr(TPC_ASR_ADDR, 8'h00);
		xtal_en <= 1'b0;
		settle();
		check({33'h0, crystal_pins_released}, 34'h0);
		$display("test async clock done");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
